// *** core/cp_effects_pkg.sv ***
// Constants, op codes and state encoding for the channel program effects
package cp_effects_pkg;
  // Op codes presented with op_start_i
  localparam logic [4:0] OP_OUT_LR = 5'h00;
  localparam logic [4:0] OP_IN_LR = 5'h01;
  localparam logic [4:0] OP_OUT_IPR = 5'h02;
  localparam logic [4:0] OP_IN_IPR = 5'h03;
  localparam logic [4:0] OP_SEND = 5'h04;
  localparam logic [4:0] OP_RECEIVE_CHAR_OP = 5'h05;
  localparam logic [4:0] OP_SYNC = 5'h06;
  localparam logic [4:0] OP_NEXT_BLK = 5'h07;
  localparam logic [4:0] OP_BR_LAST_T = 5'h08;
  localparam logic [4:0] OP_BR_LAST_F = 5'h09;
  localparam logic [4:0] OP_LOAD = 5'h0A;
  localparam logic [4:0] OP_STORE = 5'h0B;
  localparam logic [4:0] OP_WAIT = 5'h0C;
  localparam logic [4:0] OP_CPU_INTERRUPT_REQUEST_OP = 5'h0D;
  localparam logic [4:0] OP_TLU = 5'h0E;
  // Line control table geometry and byte indices
  localparam int TBL_AW = 6;
  localparam int TBL_DEPTH = 64;
  localparam logic [5:0] RX_CFG_BYTE = 6'h02;
  localparam logic [5:0] RX_STAT_BYTE = 6'h10;
  localparam logic [5:0] DSC_BYTE = 6'h14;
  localparam logic [5:0] TX_CFG_BYTE = 6'h22;
  localparam logic [5:0] TX_STAT_BYTE = 6'h30;
  localparam logic [5:0] LAST_COPY_BYTE = 6'h3E;
  // Bit positions; table bit 0 is the most significant vector bit
  localparam int ERR_TX_POS = 0;
  localparam int ERR_RX_POS = 1;
  localparam int STAT_ERR_POS = 5;
  localparam int SVC_ERR_POS = 3;
  localparam int RX_ON_POS = 6;
  localparam int LUT_MODE_POS = 7;
  localparam int LAST_POS = 7;
  localparam logic [7:0] CPU_INTERRUPT_REQUEST_OP_VALUE = 8'h80;
  // Line register numbers
  localparam logic [2:0] DATA_REG = 3'h1;
  localparam logic [2:0] DSC_REG = 3'h2;
  // Sequence counter steps
  localparam logic [15:0] SEQ_NEXT = 16'h0001;
  localparam logic [15:0] SEQ_BRANCH = 16'h0003;
  // Context save time
  localparam int WAIT_NS = 9400;
  localparam int CLK_NS = 20;
  localparam int WAIT_CYC = (WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [8:0] WAIT_LAST = 9'(WAIT_CYC - 1);
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_RD = 7'b0000010,
    S_LUT = 7'b0000100,
    S_SAVE = 7'b0001000,
    S_SLEEP = 7'b0010000,
    S_RESTORE = 7'b0100000,
    S_SYNC_ON = 7'b1000000
  } state_type;
endpackage

// *** core/channel_program_effects.sv ***
// Channel program instruction side effects on adapter, table and blocks
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Up to eight line registers reachable, addressed by op operand.
// - Eight interface package registers reachable directly by op operand.
// - Output to absent line register does nothing; input returns whatever.
// - Send ORs error status bit 7 into table byte 48 bit 2.
// - Receive ORs error status bit 6 into table byte 16 bit 2.
// - Raw data output transmits without status copy or check generation.
// - Raw data input receives without checking or status copy.
// - Sync search turns reception off, then on while ORing receive-on into byte 20.
// - Two consecutive sync characters declare sync; later characters pass.
// - Next block fetch copies last-block bit; branches test that copy.
// - Without valid block, load acts as wait and store as no-op.
// - Such a miss flags service error, byte 48 bit 4, when block arrives.
// - Wait saves context in 9.4 us, restores on next channel request.
// - Restore loads byte 2 or 34 into the check hardware.
// - DMA outside the current block's data bounds is blocked.
// - Interrupt request clears byte 16 then sets only its bit 0.
// - Look-up operand names two table bytes holding a 16-bit pointer.
// - Look-up adds working byte, fetches, bit 0 picks translate or branch.
// - Translate loads fetched byte, continues right after look-up.
// - Branch keeps working byte, counter advances 3 plus twice bits 1-7.
module channel_program_effects import cp_effects_pkg::*; (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Instruction request
  input wire logic op_start_i,
  input wire logic [4:0] op_code_i,
  input wire logic [7:0] op_operand_i,
  input wire logic tx_chan_i,
  input wire logic [15:0] seq_i,
  input wire logic [7:0] wb_i,
  // Instruction result
  output logic op_done_o,
  output logic [15:0] next_seq_o,
  output logic [7:0] wb_o,
  output logic branch_taken_o,
  output logic cpu_irq_o,
  output logic [7:0] crc_cfg_o,
  output logic crc_gen_o,
  output logic crc_check_o,
  // Adapter register access
  output logic ipr_sel_o,
  output logic [2:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic [7:0] line_reg_present_i,
  input wire logic [7:0] err_status_i,
  // Receive character stream
  input wire logic rx_char_valid_i,
  input wire logic [7:0] rx_char_i,
  input wire logic [7:0] sync_char_i,
  output logic rx_pass_valid_o,
  output logic [7:0] rx_pass_data_o,
  output logic rx_hunting_o,
  // Control block and DMA
  input wire logic block_valid_i,
  input wire logic block_last_i,
  input wire logic dma_req_i,
  input wire logic [15:0] dma_addr_i,
  input wire logic [15:0] dma_lo_i,
  input wire logic [15:0] dma_hi_i,
  output logic dma_grant_o,
  // Channel program RAM read port
  output logic ram_rd_o,
  output logic [15:0] ram_addr_o,
  input wire logic [7:0] ram_rdata_i,
  // Host table port
  input wire logic tbl_wr_i,
  input wire logic [5:0] tbl_addr_i,
  input wire logic [7:0] tbl_wdata_i,
  output logic [7:0] tbl_rdata_o
);
  localparam int WAIT_BOUND = WAIT_CYC;
  state_type state;
  logic [7:0] line_control_table [0:TBL_DEPTH-1];
  logic [15:0] seq_q;
  logic [7:0] wb_q;
  logic chan_q;
  logic missed;
  logic sync_seen;
  logic [8:0] wait_cnt;
  logic eng_we;
  logic [5:0] eng_wa;
  logic [7:0] eng_wd;
  logic svc_set;
  logic go;
  logic [2:0] idx;
  logic [5:0] ptr_lo;
  logic [7:0] cfg_byte;

  assign go = op_start_i && (state == S_IDLE);
  assign idx = op_operand_i[2:0];
  assign ptr_lo = TBL_AW'(op_operand_i[5:0] + 6'h01);
  assign svc_set = missed && block_valid_i;
  assign cfg_byte = chan_q ? line_control_table[TX_CFG_BYTE] : line_control_table[RX_CFG_BYTE];

  // Table updates decided by the engine
  always_comb begin
    eng_we = 1'b0;
    eng_wa = DSC_BYTE;
    eng_wd = line_control_table[DSC_BYTE] | (8'h01 << RX_ON_POS);
    if (state == S_SYNC_ON) begin
      eng_we = 1'b1;
    end else if (go) begin
      unique case (op_code_i)
        OP_SEND: begin
          eng_we = line_reg_present_i[DATA_REG];
          eng_wa = TX_STAT_BYTE;
          eng_wd = line_control_table[TX_STAT_BYTE] |
            (8'(err_status_i[ERR_TX_POS]) << STAT_ERR_POS);
        end
        OP_RECEIVE_CHAR_OP: begin
          eng_we = 1'b1;
          eng_wa = RX_STAT_BYTE;
          eng_wd = line_control_table[RX_STAT_BYTE] |
            (8'(err_status_i[ERR_RX_POS]) << STAT_ERR_POS);
        end
        OP_NEXT_BLK: begin
          eng_we = 1'b1;
          eng_wa = LAST_COPY_BYTE;
          eng_wd = 8'(block_last_i) << LAST_POS;
        end
        OP_CPU_INTERRUPT_REQUEST_OP: begin
          eng_we = 1'b1;
          eng_wa = RX_STAT_BYTE;
          eng_wd = CPU_INTERRUPT_REQUEST_OP_VALUE;
        end
        default: begin
          eng_we = 1'b0;
        end
      endcase
    end
  end

  // Table storage; later writes win, so the service error set wins
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int i = 0; i < TBL_DEPTH; i++) begin
        line_control_table[i] <= 8'h00;
      end
    end else begin
      if (tbl_wr_i) begin
        line_control_table[tbl_addr_i] <= tbl_wdata_i;
      end
      if (eng_we) begin
        line_control_table[eng_wa] <= eng_wd;
      end
      if (svc_set) begin
        line_control_table[TX_STAT_BYTE][SVC_ERR_POS] <= 1'b1;
      end
    end
  end

  // Host read back
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tbl_rdata_o <= 8'h00;
    end else begin
      tbl_rdata_o <= line_control_table[tbl_addr_i];
    end
  end

  // Missing block memory, cleared once a block shows up
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      missed <= 1'b0;
    end else if (go && !block_valid_i &&
                 (op_code_i == OP_LOAD || op_code_i == OP_STORE)) begin
      missed <= 1'b1;
    end else if (svc_set) begin
      missed <= 1'b0;
    end
  end

  // Instruction sequencer
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state <= S_IDLE;
      op_done_o <= 1'b0;
      next_seq_o <= 16'h0000;
      wb_o <= 8'h00;
      branch_taken_o <= 1'b0;
      cpu_irq_o <= 1'b0;
      crc_cfg_o <= 8'h00;
      crc_gen_o <= 1'b0;
      crc_check_o <= 1'b0;
      ipr_sel_o <= 1'b0;
      reg_addr_o <= 3'h0;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      reg_wdata_o <= 8'h00;
      ram_rd_o <= 1'b0;
      ram_addr_o <= 16'h0000;
      seq_q <= 16'h0000;
      wb_q <= 8'h00;
      chan_q <= 1'b0;
      wait_cnt <= 9'h000;
    end else begin
      op_done_o <= 1'b0;
      cpu_irq_o <= 1'b0;
      crc_gen_o <= 1'b0;
      crc_check_o <= 1'b0;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      ram_rd_o <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (op_start_i) begin
            seq_q <= seq_i;
            wb_q <= wb_i;
            chan_q <= tx_chan_i;
            ipr_sel_o <= 1'b0;
            reg_wdata_o <= wb_i;
            unique case (op_code_i)
              OP_OUT_LR, OP_SEND: begin
                reg_addr_o <= (op_code_i == OP_SEND) ? DATA_REG : idx;
                // Absent register: no write strobe
                reg_wr_o <= line_reg_present_i[
                  (op_code_i == OP_SEND) ? DATA_REG : idx];
                crc_gen_o <= (op_code_i == OP_SEND);
                op_done_o <= 1'b1;
              end
              OP_IN_LR, OP_RECEIVE_CHAR_OP: begin
                reg_addr_o <= (op_code_i == OP_RECEIVE_CHAR_OP) ? DATA_REG : idx;
                reg_rd_o <= 1'b1;
                // Check strobe rides with the read; raw input skips it
                crc_check_o <= (op_code_i == OP_RECEIVE_CHAR_OP);
                state <= S_RD;
              end
              OP_OUT_IPR: begin
                ipr_sel_o <= 1'b1;
                reg_addr_o <= idx;
                reg_wr_o <= 1'b1;
                op_done_o <= 1'b1;
              end
              OP_IN_IPR: begin
                ipr_sel_o <= 1'b1;
                reg_addr_o <= idx;
                reg_rd_o <= 1'b1;
                state <= S_RD;
              end
              OP_SYNC: begin
                // Receive-on dropped first, raised next cycle
                reg_addr_o <= DSC_REG;
                reg_wdata_o <= line_control_table[DSC_BYTE] & ~(8'h01 << RX_ON_POS);
                reg_wr_o <= 1'b1;
                state <= S_SYNC_ON;
              end
              OP_BR_LAST_T, OP_BR_LAST_F: begin
                branch_taken_o <= line_control_table[LAST_COPY_BYTE][LAST_POS] ^
                  (op_code_i == OP_BR_LAST_F);
                op_done_o <= 1'b1;
              end
              OP_LOAD, OP_WAIT: begin
                if (op_code_i == OP_WAIT || !block_valid_i) begin
                  wait_cnt <= WAIT_LAST;
                  state <= S_SAVE;
                end else begin
                  op_done_o <= 1'b1;
                end
              end
              OP_CPU_INTERRUPT_REQUEST_OP: begin
                cpu_irq_o <= 1'b1;
                op_done_o <= 1'b1;
              end
              OP_TLU: begin
                // Pointer high byte first, 16-bit wrap on the sum
                ram_addr_o <= 16'({line_control_table[op_operand_i[5:0]], line_control_table[ptr_lo]} +
                  {8'h00, wb_i});
                ram_rd_o <= 1'b1;
                state <= S_LUT;
              end
              default: begin
                // Store, next block fetch: table side effect only
                op_done_o <= 1'b1;
              end
            endcase
          end
        end
        S_RD: begin
          wb_o <= reg_rdata_i;
          op_done_o <= 1'b1;
          state <= S_IDLE;
        end
        S_LUT: begin
          if (ram_rdata_i[LUT_MODE_POS]) begin
            wb_o <= wb_q;
            next_seq_o <= seq_q + SEQ_BRANCH +
              {8'h00, ram_rdata_i[6:0], 1'b0};
          end else begin
            wb_o <= ram_rdata_i;
            next_seq_o <= seq_q + SEQ_NEXT;
          end
          op_done_o <= 1'b1;
          state <= S_IDLE;
        end
        S_SAVE: begin
          // Context save time; channel requests are not seen yet
          if (wait_cnt == 9'h000) begin
            state <= S_SLEEP;
          end else begin
            wait_cnt <= wait_cnt - 9'h001;
          end
        end
        S_SLEEP: begin
          if (op_start_i) begin
            state <= S_RESTORE;
          end
        end
        S_RESTORE: begin
          crc_cfg_o <= cfg_byte;
          wb_o <= wb_q;
          next_seq_o <= seq_q + SEQ_NEXT;
          op_done_o <= 1'b1;
          state <= S_IDLE;
        end
        S_SYNC_ON: begin
          reg_wdata_o <= line_control_table[DSC_BYTE] | (8'h01 << RX_ON_POS);
          reg_wr_o <= 1'b1;
          op_done_o <= 1'b1;
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Sync hunt: two sync characters in a row end it
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rx_hunting_o <= 1'b0;
      sync_seen <= 1'b0;
      rx_pass_valid_o <= 1'b0;
      rx_pass_data_o <= 8'h00;
    end else begin
      rx_pass_valid_o <= rx_char_valid_i && !rx_hunting_o;
      rx_pass_data_o <= rx_char_i;
      if (go && op_code_i == OP_SYNC) begin
        rx_hunting_o <= 1'b1;
        sync_seen <= 1'b0;
      end else if (rx_char_valid_i && rx_hunting_o) begin
        sync_seen <= (rx_char_i == sync_char_i);
        if (sync_seen && rx_char_i == sync_char_i) begin
          rx_hunting_o <= 1'b0;
        end
      end
    end
  end

  // DMA guard against the block's data bounds
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      dma_grant_o <= 1'b0;
    end else begin
      dma_grant_o <= dma_req_i && dma_addr_i >= dma_lo_i &&
        dma_addr_i <= dma_hi_i;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  a_send_copy: assert property (go && op_code_i == OP_SEND &&
    line_reg_present_i[DATA_REG] && err_status_i[ERR_TX_POS]
    |=> line_control_table[TX_STAT_BYTE][STAT_ERR_POS] && reg_wr_o && crc_gen_o)
    else $error("send did not copy error status");
  a_raw_nocopy: assert property (go && op_code_i == OP_OUT_LR &&
    !tbl_wr_i && !svc_set
    |=> line_control_table[TX_STAT_BYTE] == $past(line_control_table[TX_STAT_BYTE]) && !crc_gen_o)
    else $error("raw output touched status");
  a_receive_char_op_copy: assert property (go && op_code_i == OP_RECEIVE_CHAR_OP &&
    err_status_i[ERR_RX_POS] |=> line_control_table[RX_STAT_BYTE][STAT_ERR_POS] &&
    crc_check_o ##1
    op_done_o && wb_o == $past(reg_rdata_i))
    else $error("receive status copy missing");
  a_raw_nocheck: assert property (go && op_code_i == OP_IN_LR
    |=> reg_rd_o && !crc_check_o)
    else $error("raw input was checked");
  a_absent_nop: assert property (go && op_code_i == OP_OUT_LR &&
    !line_reg_present_i[idx] |=> !reg_wr_o)
    else $error("write to absent register");
  a_cpu_interrupt_request_op_byte: assert property (go && op_code_i == OP_CPU_INTERRUPT_REQUEST_OP &&
    !tbl_wr_i |=> line_control_table[RX_STAT_BYTE] == CPU_INTERRUPT_REQUEST_OP_VALUE && cpu_irq_o)
    else $error("interrupt byte wrong");
  a_sync_order: assert property (go && op_code_i == OP_SYNC
    |=> reg_wr_o && !reg_wdata_o[RX_ON_POS] && reg_addr_o == DSC_REG ##1
    reg_wr_o && reg_wdata_o[RX_ON_POS] && line_control_table[DSC_BYTE][RX_ON_POS])
    else $error("sync search order wrong");
  a_wait_time: assert property ($rose(state == S_SAVE)
    |-> ##[WAIT_BOUND:WAIT_BOUND] $rose(state == S_SLEEP))
    else $error("context save time wrong");
  a_load_wait: assert property (go && op_code_i == OP_LOAD &&
    !block_valid_i |=> state == S_SAVE && missed)
    else $error("load without block not a wait");
  a_svc_flag: assert property (svc_set
    |=> line_control_table[TX_STAT_BYTE][SVC_ERR_POS] && !missed)
    else $error("service error not flagged");
  a_lut_xlate: assert property (state == S_LUT &&
    !ram_rdata_i[LUT_MODE_POS] |=> wb_o == $past(ram_rdata_i) &&
    next_seq_o == $past(seq_q) + SEQ_NEXT)
    else $error("translation result wrong");
  a_lut_branch: assert property (state == S_LUT &&
    ram_rdata_i[LUT_MODE_POS] |=> wb_o == $past(wb_q) &&
    next_seq_o == $past(seq_q) + SEQ_BRANCH +
    {8'h00, $past(ram_rdata_i[6:0]), 1'b0})
    else $error("indexed branch result wrong");
  a_last_copy: assert property (go && op_code_i == OP_BR_LAST_T
    |=> branch_taken_o == $past(line_control_table[LAST_COPY_BYTE][LAST_POS]))
    else $error("last block branch wrong");
  a_dma_bound: assert property (dma_grant_o |->
    $past(dma_addr_i) <= $past(dma_hi_i) &&
    $past(dma_addr_i) >= $past(dma_lo_i))
    else $error("DMA outside bounds");
  c_tlu_branch: cover property (state == S_LUT &&
    ram_rdata_i[LUT_MODE_POS]);
  c_sync_found: cover property ($fell(rx_hunting_o));
  c_restore: cover property (state == S_RESTORE);
  c_svc_err: cover property (svc_set);
endmodule
`default_nettype wire

// *** tb/adapter_model.sv ***
// Line adapter model: eight line and eight interface package registers
`timescale 1ns/1ns
`default_nettype none
module adapter_model (
  // Clock
  input wire logic clk_sys_i,
  // Register access from the processor
  input wire logic ipr_sel_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o
);
  logic [7:0] lr [8] = '{default: 8'h00};
  logic [7:0] ipr [8] = '{default: 8'h00};
  logic [7:0] cur;
  logic [7:0] last = 8'h00;
  logic rd_q = 1'b0;
  // Writes land on the strobe edge
  always @(posedge clk_sys_i) begin
    if (reg_wr_i === 1'b1 && ipr_sel_i === 1'b1) begin
      ipr[reg_addr_i] <= reg_wdata_i;
    end
    if (reg_wr_i === 1'b1 && ipr_sel_i === 1'b0) begin
      lr[reg_addr_i] <= reg_wdata_i;
    end
    rd_q <= reg_rd_i;
    last <= reg_rdata_o;
  end
  // Data held with and after the read; otherwise it toggles every cycle
  // so a late sample cannot pass by luck
  assign cur = ipr_sel_i ? ipr[reg_addr_i] : lr[reg_addr_i];
  assign reg_rdata_o = (reg_rd_i || rd_q) ? cur : ~last;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the channel program effects block
`timescale 1ns/1ns
`default_nettype none
module tb_top import cp_effects_pkg::*;;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, op_start_i = 1'b0, tx_chan_i = 1'b0;
  logic [4:0] op_code_i = 5'h00;
  logic [7:0] op_operand_i = 8'h00, wb_i = 8'h00, err_status_i = 8'h03;
  logic [15:0] seq_i = 16'h0000, dma_addr_i = 16'h0000;
  logic [15:0] dma_lo_i = 16'h0100, dma_hi_i = 16'h01FF;
  logic [7:0] reg_rdata_i, line_reg_present_i = 8'hF7, ram_rdata_i;
  logic rx_char_valid_i = 1'b0, block_valid_i = 1'b0, block_last_i = 1'b0;
  logic [7:0] rx_char_i = 8'h00, sync_char_i = 8'h16, ram_val = 8'h00;
  logic dma_req_i = 1'b0, tbl_wr_i = 1'b0, ram_q = 1'b0;
  logic [5:0] tbl_addr_i = 6'h00;
  logic [7:0] tbl_wdata_i = 8'h00, prev_w = 8'h00;
  logic op_done_o, branch_taken_o, cpu_irq_o, crc_gen_o, crc_check_o;
  logic ipr_sel_o, reg_wr_o, reg_rd_o, rx_pass_valid_o, rx_hunting_o;
  logic dma_grant_o, ram_rd_o;
  logic [15:0] next_seq_o, ram_addr_o, got_addr = 16'h0000;
  logic [7:0] wb_o, crc_cfg_o, reg_wdata_o, rx_pass_data_o, tbl_rdata_o;
  logic [2:0] reg_addr_o;
  int err_count = 0, n_tests = 0, cyc = 0, lat = 0, d = 0;
  int irqs = 0, passes = 0, dones = 0, chks = 0;
  typedef struct packed {
    logic [15:0] ptr;
    logic [7:0] wb;
    logic [7:0] ram;
    logic [15:0] addr;
    logic [7:0] wb_n;
    logic [15:0] seq_n;
  } lut_row_type;
  // Look-up rows, sequence counter at 16'h0303 on the displacement byte
  lut_row_type rows [5] = '{
    '{16'h0200, 8'h63, 8'h43, 16'h0263, 8'h43, 16'h0304},
    '{16'h0200, 8'h03, 8'h8B, 16'h0203, 8'h03, 16'h031C},
    '{16'h0200, 8'hC3, 8'h43, 16'h02C3, 8'h43, 16'h0304},
    '{16'hFFF0, 8'h20, 8'hFF, 16'h0010, 8'h20, 16'h0404},
    '{16'h0000, 8'hFF, 8'h80, 16'h00FF, 8'hFF, 16'h0306}};
  logic [15:0] dmas [4] = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200};
  logic [3:0] dma_ok = 4'b0110; // Grant expected for each address above

  channel_program_effects channel_program_effects_i (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .op_start_i(op_start_i),
    .op_code_i(op_code_i), .op_operand_i(op_operand_i),
    .tx_chan_i(tx_chan_i), .seq_i(seq_i), .wb_i(wb_i),
    .op_done_o(op_done_o), .next_seq_o(next_seq_o), .wb_o(wb_o),
    .branch_taken_o(branch_taken_o), .cpu_irq_o(cpu_irq_o),
    .crc_cfg_o(crc_cfg_o), .crc_gen_o(crc_gen_o),
    .crc_check_o(crc_check_o), .ipr_sel_o(ipr_sel_o),
    .reg_addr_o(reg_addr_o), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o),
    .reg_wdata_o(reg_wdata_o), .reg_rdata_i(reg_rdata_i),
    .line_reg_present_i(line_reg_present_i), .err_status_i(err_status_i),
    .rx_char_valid_i(rx_char_valid_i), .rx_char_i(rx_char_i),
    .sync_char_i(sync_char_i), .rx_pass_valid_o(rx_pass_valid_o),
    .rx_pass_data_o(rx_pass_data_o), .rx_hunting_o(rx_hunting_o),
    .block_valid_i(block_valid_i), .block_last_i(block_last_i),
    .dma_req_i(dma_req_i), .dma_addr_i(dma_addr_i), .dma_lo_i(dma_lo_i),
    .dma_hi_i(dma_hi_i), .dma_grant_o(dma_grant_o), .ram_rd_o(ram_rd_o),
    .ram_addr_o(ram_addr_o), .ram_rdata_i(ram_rdata_i),
    .tbl_wr_i(tbl_wr_i), .tbl_addr_i(tbl_addr_i),
    .tbl_wdata_i(tbl_wdata_i), .tbl_rdata_o(tbl_rdata_o));

  adapter_model adapter_model_i (
    .clk_sys_i(clk_sys_i), .ipr_sel_i(ipr_sel_o), .reg_addr_i(reg_addr_o),
    .reg_wr_i(reg_wr_o), .reg_rd_i(reg_rd_o), .reg_wdata_i(reg_wdata_o),
    .reg_rdata_o(reg_rdata_i));

  // Clock
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // Event counters and timeout; pulses are counted on the following edge
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    ram_q <= ram_rd_o;
    if (ram_rd_o === 1'b1) got_addr <= ram_addr_o;
    if (reg_wr_o === 1'b1) prev_w <= reg_wdata_o;
    if (cpu_irq_o === 1'b1) irqs <= irqs + 1;
    if (rx_pass_valid_o === 1'b1) passes <= passes + 1;
    if (op_done_o === 1'b1) dones <= dones + 1;
    if (crc_check_o === 1'b1) chks <= chks + 1;
    if (cyc == 12000) begin
      err_count++;
      stop_test();
    end
  end
  // RAM answers with and after the read, else the inverse
  assign ram_rdata_i = (ram_rd_o === 1'b1 || ram_q) ? ram_val : ~ram_val;

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      err_count++;
    end
  endtask

  // One instruction; sl covers a sleep ended by a channel request
  task automatic op(input logic [4:0] c, input logic [7:0] a, input bit sl);
    @(posedge clk_sys_i);
    op_code_i <= c;
    op_operand_i <= a;
    op_start_i <= 1'b1;
    @(posedge clk_sys_i);
    op_start_i <= 1'b0;
    lat = 1;
    if (sl) begin
      repeat (479) @(posedge clk_sys_i);
      wb_i <= 8'h00;
      seq_i <= 16'h0000;
      op_code_i <= OP_STORE;
      op_start_i <= 1'b1;
      @(posedge clk_sys_i);
      op_start_i <= 1'b0;
      lat = 481;
    end
    @(negedge clk_sys_i);
    while (op_done_o !== 1'b1 && lat < 1000) begin
      @(negedge clk_sys_i);
      lat++;
    end
  endtask

  task automatic wtb(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    tbl_wr_i <= 1'b1;
    tbl_addr_i <= a;
    tbl_wdata_i <= v;
    @(posedge clk_sys_i);
    tbl_wr_i <= 1'b0;
  endtask

  task automatic rtb(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    tbl_addr_i <= a;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk(tbl_rdata_o, e);
  endtask

  task automatic rxc(input logic [7:0] v);
    @(posedge clk_sys_i);
    rx_char_valid_i <= 1'b1;
    rx_char_i <= v;
    @(posedge clk_sys_i);
    rx_char_valid_i <= 1'b0;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(negedge clk_sys_i);
    chk({op_done_o, rx_hunting_o, dma_grant_o, cpu_irq_o, reg_wr_o}, 0);
    rtb(TX_STAT_BYTE, 8'h00);
    $display("test reset done");
    // Look-up rows through table bytes 23 and 24
    foreach (rows[i]) begin
      wtb(6'h17, rows[i].ptr[15:8]);
      wtb(6'h18, rows[i].ptr[7:0]);
      wb_i <= rows[i].wb;
      seq_i <= 16'h0303;
      ram_val <= rows[i].ram;
      op(OP_TLU, 8'h17, 0);
      chk(got_addr, rows[i].addr);
      chk(wb_o, rows[i].wb_n);
      chk(next_seq_o, rows[i].seq_n);
    end
    $display("test look-up done");
    // All line and interface registers; line register 3 is absent
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys_i);
      wb_i <= 8'(8'h30 + k);
      op(k < 8 ? OP_OUT_LR : OP_OUT_IPR, 8'(k % 8), 0);
      chk(reg_wr_o, k != 3);
      chk(ipr_sel_o, k > 7);
      if (k != 3) begin
        op(k < 8 ? OP_IN_LR : OP_IN_IPR, 8'(k % 8), 0);
        chk(wb_o, 8'(8'h30 + k));
      end
    end
    $display("test registers done");
    // Both error bits set: each op copies only its own
    @(posedge clk_sys_i);
    wb_i <= 8'h5A;
    op(OP_SEND, 8'h01, 0);
    chk({crc_gen_o, reg_wr_o, reg_addr_o}, 5'h19);
    chk(reg_wdata_o, 8'h5A);
    rtb(TX_STAT_BYTE, 8'h20);
    rtb(RX_STAT_BYTE, 8'h00);
    wtb(TX_STAT_BYTE, 8'h00);
    wb_i <= 8'h6B;
    op(OP_OUT_LR, 8'h01, 0);
    chk({crc_gen_o, reg_wr_o}, 2'h1);
    rtb(TX_STAT_BYTE, 8'h00);
    d = chks;
    op(OP_RECEIVE_CHAR_OP, 8'h01, 0);
    chk(wb_o, 8'h6B);
    chk(chks - d, 1);
    rtb(RX_STAT_BYTE, 8'h20);
    wtb(RX_STAT_BYTE, 8'h00);
    op(OP_IN_LR, 8'h01, 0);
    chk(wb_o, 8'h6B);
    chk(chks - d, 1);
    rtb(RX_STAT_BYTE, 8'h00);
    $display("test status copy done");
    wtb(RX_STAT_BYTE, 8'hFF);
    op(OP_CPU_INTERRUPT_REQUEST_OP, 8'h00, 0);
    rtb(RX_STAT_BYTE, 8'h80);
    chk(irqs, 1);
    $display("test interrupt done");
    // Sync search; the mirror byte holds other control bits
    wtb(DSC_BYTE, 8'h81);
    op(OP_SYNC, 8'h00, 0);
    chk({reg_wr_o, reg_addr_o, reg_wdata_o}, 12'hAC1);
    chk(prev_w, 8'h81);
    rtb(DSC_BYTE, 8'hC1);
    d = passes;
    rxc(8'h16);
    rxc(8'h33);
    rxc(8'h16);
    @(negedge clk_sys_i);
    chk(rx_hunting_o, 1'b1);
    rxc(8'h16);
    rxc(8'h77);
    repeat (2) @(negedge clk_sys_i);
    chk(rx_hunting_o, 1'b0);
    chk(passes - d, 1);
    chk(rx_pass_data_o, 8'h77);
    $display("test sync done");
    // Branches test the copy, not the live indicator
    for (int l = 1; l >= 0; l--) begin
      @(posedge clk_sys_i);
      block_valid_i <= 1'b1;
      block_last_i <= l[0];
      op(OP_NEXT_BLK, 8'h00, 0);
      @(posedge clk_sys_i);
      block_last_i <= ~l[0];
      op(OP_BR_LAST_T, 8'h00, 0);
      chk(branch_taken_o, l[0]);
      op(OP_BR_LAST_F, 8'h00, 0);
      chk(branch_taken_o, !l[0]);
    end
    $display("test last block done");
    // Missing block: store is a no-op, load sleeps, flag on arrival
    @(posedge clk_sys_i);
    block_valid_i <= 1'b0;
    wtb(TX_STAT_BYTE, 8'h00);
    op(OP_STORE, 8'h00, 0);
    chk(lat, 1);
    rtb(TX_STAT_BYTE, 8'h00);
    d = dones;
    op(OP_LOAD, 8'h00, 1);
    @(negedge clk_sys_i);
    chk(dones - d, 1);
    @(posedge clk_sys_i);
    block_valid_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rtb(TX_STAT_BYTE, 8'h08);
    $display("test missing block done");
    // Wait on each channel; inputs change while asleep
    wtb(RX_CFG_BYTE, 8'h05);
    wtb(TX_CFG_BYTE, 8'h3C);
    for (int t = 0; t < 2; t++) begin
      @(posedge clk_sys_i);
      tx_chan_i <= t[0];
      wb_i <= 8'h9E;
      seq_i <= 16'h1234;
      d = dones;
      op(OP_WAIT, 8'h00, 1);
      chk(crc_cfg_o, t ? 8'h3C : 8'h05);
      chk(wb_o, 8'h9E);
      chk(next_seq_o, 16'h1235);
      @(negedge clk_sys_i);
      chk(dones - d, 1);
    end
    $display("test wait done");
    // Range edges around the current block's data area
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      dma_req_i <= 1'b1;
      dma_addr_i <= dmas[i];
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk(dma_grant_o, dma_ok[i]);
    end
    // In-range address without a request: no grant
    @(posedge clk_sys_i);
    dma_req_i <= 1'b0;
    dma_addr_i <= 16'h0100;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk(dma_grant_o, 1'b0);
    $display("test dma done");
    stop_test();
  end
endmodule
`default_nettype wire
